// >>> hw/ilp_core.sv
// LED PWM controller core: APB and serial-bus register file, group PWM and 16 channels
// Function
// - Each channel has its own 8-bit PWM, duty 0 to 255/256.
// - Shared 8-bit group PWM dims at fixed rate or blinks at programmable period.
// - Each channel is off, on, own PWM, or own PWM with group PWM.
// - Output-enable input high switches every channel off.
// - Software reset call resets all registers and outputs as at power-on.
// - Settings apply at each acknowledge or at stop; stop is default.
// - Group and three sub-call addresses answer, each enabled by software.
// - Sub-call address one is enabled after reset by default.
// - Hardware address comes from the address pins, four or three of them.
// - Channel duties reset to fully off; 256 linear steps.
// - Group duty resets to maximum, 255/256, so dimming gates channels off for one step per group period.
// - Programmable delay staggers channel turn-on edges.
// - Open, short and overtemperature flags are kept in a readable status register.
// - An 8-bit code sets the sink peak current.
// - All timing runs from the one internal clock.
// - Channels stay off through reset and power-up.
// - Serial clock and data are filtered against short spikes.
// - Reset input low resets the device.
`timescale 1ns/1ps
module ilp_core #(
  parameter int ADDR_PINS = 4
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [ADDR_PINS-1:0] hardware_address_inputs_i,
  input wire logic output_enable_n_i,
  input wire logic open_load_i,
  input wire logic short_load_i,
  input wire logic overtemp_i,
  output logic [ilp_pkg::NUM_CH-1:0] channel_sink_output_o,
  output logic [7:0] iref_code_o
);
  localparam int NR = ilp_pkg::NUM_REG;
  localparam int IW = ilp_pkg::IDX_W;
  localparam int SW = ilp_pkg::SYNC_W + ADDR_PINS;
  localparam int PW = ilp_pkg::PRE_W;

  function automatic logic in_map(input logic [7:0] idx);
    return idx < 8'(NR);
  endfunction : in_map

  function automatic logic [7:0] rst_val(input int idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx == ilp_pkg::REG_MODE) v = ilp_pkg::MODE_RST;
    else if (idx == ilp_pkg::REG_GRP_DUTY) v = ilp_pkg::GRP_DUTY_RST;
    else if (idx == ilp_pkg::REG_ADR_GRP) v = ilp_pkg::ADR_GRP_RST;
    else if (idx == ilp_pkg::REG_ADR_GRP + 1) v = ilp_pkg::ADR_SUB1_RST;
    else if (idx == ilp_pkg::REG_ADR_GRP + 2) v = ilp_pkg::ADR_SUB2_RST;
    else if (idx == ilp_pkg::REG_ADR_GRP + 3) v = ilp_pkg::ADR_SUB3_RST;
    return v;
  endfunction : rst_val

  // Pin synchronisers; only the second stage is read
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_r <= SW'(ilp_pkg::SYNC_RST);
      sync2_r <= SW'(ilp_pkg::SYNC_RST);
    end else begin
      sync1_r <= {hardware_address_inputs_i, overtemp_i, short_load_i, open_load_i,
                  output_enable_n_i, sda_i, scl_i};
      sync2_r <= sync1_r;
    end
  end

  // Spike filter: a line changes only after it disagrees for FILT_CYC clocks
  logic [1:0] filt_r;
  logic [1:0] filt_nxt;
  logic [1:0] prev_r;
  logic [ilp_pkg::FILT_W-1:0] fcnt_r [2];
  logic [ilp_pkg::FILT_W-1:0] fcnt_nxt [2];
  always_comb begin
    filt_nxt = filt_r;
    for (int i = 0; i < 2; i++) begin
      fcnt_nxt[i] = '0;
      if (sync2_r[i] != filt_r[i]) begin
        if (fcnt_r[i] == ilp_pkg::FILT_W'(ilp_pkg::FILT_CYC - 1)) filt_nxt[i] = sync2_r[i];
        else fcnt_nxt[i] = fcnt_r[i] + 1'b1;
      end
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      filt_r <= 2'h3;
      prev_r <= 2'h3;
      fcnt_r <= '{default: '0};
    end else begin
      filt_r <= filt_nxt;
      prev_r <= filt_r;
      fcnt_r <= fcnt_nxt;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = filt_r[0] & ~prev_r[0];
  assign scl_fall = ~filt_r[0] & prev_r[0];
  assign bus_start = filt_r[0] & prev_r[0] & prev_r[1] & ~filt_r[1];
  assign bus_stop = filt_r[0] & prev_r[0] & ~prev_r[1] & filt_r[1];

  logic [7:0] live_r [NR];
  logic [7:0] live_nxt [NR];
  logic [7:0] stage_r [NR];
  logic [7:0] stage_nxt [NR];
  logic [NR-1:0] dirty_r, dirty_nxt;
  logic [6:0] hw_addr;
  assign hw_addr = {ilp_pkg::HW_ADDR_BASE[6:ADDR_PINS], sync2_r[SW-1:6]};

  // Serial-bus slave
  ilp_pkg::ilp_i2c_st_e st_r, st_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [1:0] nbyte_r, nbyte_nxt;
  logic [7:0] shift_r, shift_nxt, ptr_r, ptr_nxt, rd_byte;
  logic rd_r, rd_nxt, call_r, call_nxt, key_r, key_nxt, nack_r, nack_nxt;
  logic oe_r, oe_nxt, wr_stb, commit_all, soft_rst, hit_prog, accept;
  assign rd_byte = in_map(ptr_r) ? live_r[ptr_r[IW-1:0]] : 8'h00;

  always_comb begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    nbyte_nxt = nbyte_r;
    shift_nxt = shift_r;
    ptr_nxt = ptr_r;
    rd_nxt = rd_r;
    call_nxt = call_r;
    key_nxt = key_r;
    nack_nxt = nack_r;
    oe_nxt = oe_r;
    wr_stb = 1'b0;
    commit_all = 1'b0;
    soft_rst = 1'b0;
    accept = 1'b0;
    hit_prog = 1'b0;
    for (int k = 0; k < ilp_pkg::NUM_PROG_ADR; k++) begin
      if (live_r[ilp_pkg::REG_MODE][ilp_pkg::MODE_EN_GRP + k] &&
          live_r[ilp_pkg::REG_ADR_GRP + k][6:0] == shift_r[7:1]) hit_prog = 1'b1;
    end
    if (bus_stop) begin
      st_nxt = ilp_pkg::ST_IDLE;
      oe_nxt = 1'b0;
      commit_all = 1'b1;
      soft_rst = key_r;
      key_nxt = 1'b0;
    end else if (bus_start) begin
      st_nxt = ilp_pkg::ST_RX;
      bit_nxt = 4'h0;
      nbyte_nxt = 2'h0;
      oe_nxt = 1'b0;
      key_nxt = 1'b0;
    end else begin
      case (st_r)
        ilp_pkg::ST_RX: begin
          if (scl_rise && bit_r != 4'h8) begin
            shift_nxt = {shift_r[6:0], filt_r[1]};
            bit_nxt = bit_r + 4'h1;
          end else if (scl_fall && bit_r == 4'h8) begin
            bit_nxt = 4'h0;
            if (nbyte_r == 2'h0) begin
              accept = (shift_r[7:1] == hw_addr) | hit_prog |
                       (shift_r[7:1] == ilp_pkg::SOFTWARE_RESET_CALL_ADDR && !shift_r[0]);
              call_nxt = shift_r[7:1] == ilp_pkg::SOFTWARE_RESET_CALL_ADDR;
              rd_nxt = shift_r[0] & (shift_r[7:1] != ilp_pkg::SOFTWARE_RESET_CALL_ADDR);
            end else if (call_r) begin
              accept = shift_r == ilp_pkg::SOFTWARE_RESET_CALL_KEY;
              key_nxt = accept;
            end else if (nbyte_r == 2'h1) begin
              accept = 1'b1;
              ptr_nxt = shift_r;
            end else begin
              accept = 1'b1;
              wr_stb = 1'b1;
              ptr_nxt = ptr_r + 8'h01;
            end
            if (nbyte_r != 2'h2) nbyte_nxt = nbyte_r + 2'h1;
            st_nxt = accept ? ilp_pkg::ST_ACK : ilp_pkg::ST_IDLE;
            oe_nxt = accept;
          end
        end
        ilp_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (rd_r) begin
              st_nxt = ilp_pkg::ST_TX;
              shift_nxt = rd_byte;
              oe_nxt = ~rd_byte[7];
              ptr_nxt = ptr_r + 8'h01;
            end else begin
              st_nxt = ilp_pkg::ST_RX;
              oe_nxt = 1'b0;
            end
          end
        end
        ilp_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_r == 4'h7) begin
              st_nxt = ilp_pkg::ST_MACK;
              bit_nxt = 4'h0;
              oe_nxt = 1'b0;
            end else begin
              shift_nxt = {shift_r[6:0], 1'b0};
              oe_nxt = ~shift_r[6];
              bit_nxt = bit_r + 4'h1;
            end
          end
        end
        ilp_pkg::ST_MACK: begin
          if (scl_rise) begin
            nack_nxt = filt_r[1];
          end else if (scl_fall && nack_r) begin
            st_nxt = ilp_pkg::ST_IDLE;
          end else if (scl_fall) begin
            // Next byte starts on this fall; waiting in ST_ACK would slip it a whole bit, to the next fall
            st_nxt = ilp_pkg::ST_TX;
            shift_nxt = rd_byte;
            oe_nxt = ~rd_byte[7];
            ptr_nxt = ptr_r + 8'h01;
          end
        end
        default: begin
          st_nxt = ilp_pkg::ST_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= ilp_pkg::ST_IDLE;
      bit_r <= 4'h0;
      nbyte_r <= 2'h0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      rd_r <= 1'b0;
      call_r <= 1'b0;
      key_r <= 1'b0;
      nack_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      bit_r <= bit_nxt;
      nbyte_r <= nbyte_nxt;
      shift_r <= shift_nxt;
      ptr_r <= ptr_nxt;
      rd_r <= rd_nxt;
      call_r <= call_nxt;
      key_r <= key_nxt;
      nack_r <= nack_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = oe_r;

  // APB slave: zero wait states, read data captured in the setup cycle
  logic [IW-1:0] a_idx;
  logic a_map, apb_wr;
  logic [31:0] prdata_r, prdata_nxt;
  assign a_idx = paddr_i[IW+1:2];
  assign a_map = (paddr_i[1:0] == 2'h0) && in_map({2'h0, paddr_i[7:2]});
  assign apb_wr = psel_i & penable_i & pwrite_i & a_map;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~a_map;
  always_comb begin
    prdata_nxt = prdata_r;
    if (psel_i && !penable_i) prdata_nxt = a_map ? {24'h000000, live_r[a_idx]} : 32'h00000000;
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) prdata_r <= 32'h00000000;
    else prdata_r <= prdata_nxt;
  end
  assign prdata_o = prdata_r;

  // Register file; serial writes stage until stop unless acknowledge update is chosen
  always_comb begin
    live_nxt = live_r;
    stage_nxt = stage_r;
    dirty_nxt = dirty_r;
    if (wr_stb && in_map(ptr_r) && ptr_r != 8'(ilp_pkg::REG_STATUS)) begin
      if (live_r[ilp_pkg::REG_MODE][ilp_pkg::MODE_ACK_UPD]) begin
        live_nxt[ptr_r[IW-1:0]] = shift_r;
      end else begin
        stage_nxt[ptr_r[IW-1:0]] = shift_r;
        dirty_nxt[ptr_r[IW-1:0]] = 1'b1;
      end
    end
    if (commit_all) begin
      for (int i = 0; i < NR; i++) begin
        if (dirty_r[i]) live_nxt[i] = stage_r[i];
      end
      dirty_nxt = '0;
    end
    if (apb_wr) begin
      if (a_idx == IW'(ilp_pkg::REG_STATUS)) live_nxt[a_idx] = live_r[a_idx] & ~pwdata_i[7:0];
      else live_nxt[a_idx] = pwdata_i[7:0];
    end
    if (soft_rst) begin
      for (int i = 0; i < NR; i++) live_nxt[i] = rst_val(i);
      dirty_nxt = '0;
    end
    // Fault set wins over a clear in the same cycle
    live_nxt[ilp_pkg::REG_STATUS][2:0] = live_nxt[ilp_pkg::REG_STATUS][2:0] | sync2_r[5:3];
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < NR; i++) begin
        live_r[i] <= rst_val(i);
        stage_r[i] <= 8'h00;
      end
      dirty_r <= '0;
    end else begin
      live_r <= live_nxt;
      stage_r <= stage_nxt;
      dirty_r <= dirty_nxt;
    end
  end

  assign iref_code_o = live_r[ilp_pkg::REG_IREF];

  // Channel counter and group PWM, all from the one clock
  logic [7:0] pwm_cnt_r, pwm_cnt_nxt, grp_cnt_r, grp_cnt_nxt, grp_mul_r, grp_mul_nxt;
  logic [PW-1:0] pre_r, pre_nxt, pre_lim;
  logic blink, pre_tick, grp_on;
  assign blink = live_r[ilp_pkg::REG_MODE][ilp_pkg::MODE_BLINK];
  assign pre_lim = blink ? PW'(ilp_pkg::BLINK_STEP_CYC - 1) : PW'(ilp_pkg::DIM_STEP_CYC - 1);
  assign pre_tick = pre_r >= pre_lim;
  assign grp_on = grp_cnt_r < live_r[ilp_pkg::REG_GRP_DUTY];
  always_comb begin
    pwm_cnt_nxt = pwm_cnt_r + 8'h01;
    pre_nxt = pre_tick ? '0 : pre_r + 1'b1;
    grp_cnt_nxt = grp_cnt_r;
    grp_mul_nxt = grp_mul_r;
    if (pre_tick) begin
      // Blink period is (freq + 1) times the fastest blink period
      if (!blink || grp_mul_r >= live_r[ilp_pkg::REG_GRP_FREQ]) begin
        grp_mul_nxt = 8'h00;
        grp_cnt_nxt = grp_cnt_r + 8'h01;
      end else begin
        grp_mul_nxt = grp_mul_r + 8'h01;
      end
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pwm_cnt_r <= 8'h00;
      pre_r <= '0;
      grp_cnt_r <= 8'h00;
      grp_mul_r <= 8'h00;
    end else begin
      pwm_cnt_r <= pwm_cnt_nxt;
      pre_r <= pre_nxt;
      grp_cnt_r <= grp_cnt_nxt;
      grp_mul_r <= grp_mul_nxt;
    end
  end

  // Each channel sees the counter delayed by its index times the stagger code
  for (genvar g = 0; g < ilp_pkg::NUM_CH; g++) begin : g_chan
    logic [7:0] phase;
    assign phase = pwm_cnt_r - 8'(8'(g) * live_r[ilp_pkg::REG_STAGGER]);
    ilp_chan u_chan (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .mode_i(live_r[ilp_pkg::REG_CHMODE0 + g / 4][2 * (g % 4) +: 2]),
      .duty_i(live_r[ilp_pkg::REG_DUTY0 + g]),
      .phase_i(phase),
      .grp_on_i(grp_on),
      .out_en_i(~sync2_r[2]),
      .sink_o(channel_sink_output_o[g])
    );
  end

endmodule : ilp_core

// >>> hw/ilp_pkg.sv
// Shared constants for the LED PWM controller: register map, reset values, timing, encodings
package ilp_pkg;

  localparam int NUM_CH = 16;
  localparam int NUM_REG = 30;
  localparam int IDX_W = 5;

  localparam int REG_MODE = 0;
  localparam int REG_GRP_DUTY = 1;
  localparam int REG_GRP_FREQ = 2;
  localparam int REG_STAGGER = 3;
  localparam int REG_IREF = 4;
  localparam int REG_ADR_GRP = 5;
  localparam int REG_STATUS = 9;
  localparam int REG_CHMODE0 = 10;
  localparam int REG_DUTY0 = 14;

  localparam int MODE_ACK_UPD = 0;
  localparam int MODE_BLINK = 1;
  localparam int MODE_EN_GRP = 4;
  localparam int NUM_PROG_ADR = 4;

  localparam logic [7:0] MODE_RST = 8'h20;
  localparam logic [7:0] GRP_DUTY_RST = 8'hFF;
  localparam logic [7:0] ADR_GRP_RST = 8'h70;
  localparam logic [7:0] ADR_SUB1_RST = 8'h76;
  localparam logic [7:0] ADR_SUB2_RST = 8'h72;
  localparam logic [7:0] ADR_SUB3_RST = 8'h74;

  localparam logic [6:0] HW_ADDR_BASE = 7'h60;
  localparam logic [6:0] SOFTWARE_RESET_CALL_ADDR = 7'h03;
  localparam logic [7:0] SOFTWARE_RESET_CALL_KEY = 8'hA5;

  localparam int SYNC_W = 6;
  localparam logic [5:0] SYNC_RST = 6'h07;

  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int PWM_STEPS = 256;
  localparam int DIM_HZ = 122;
  localparam int BLINK_MIN_HZ = 15;
  localparam int DIM_STEP_CYC = CLK_HZ / (DIM_HZ * PWM_STEPS);
  localparam int BLINK_STEP_CYC = CLK_HZ / (BLINK_MIN_HZ * PWM_STEPS);
  localparam int PRE_W = 12;
  localparam int FILT_NS = 50;
  localparam int FILT_CYC = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int FILT_W = 2;

  typedef enum logic [1:0] {
    CM_OFF = 2'h0,
    CM_ON = 2'h1,
    CM_PWM = 2'h2,
    CM_GRP = 2'h3
  } ilp_chmode_e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_MACK = 5'h10
  } ilp_i2c_st_e;

endpackage : ilp_pkg

// >>> hw/ilp_chan.sv
// One LED channel: mode select, individual PWM compare, group gate and output enable
`timescale 1ns/1ps
module ilp_chan (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [1:0] mode_i,
  input wire logic [7:0] duty_i,
  input wire logic [7:0] phase_i,
  input wire logic grp_on_i,
  input wire logic out_en_i,
  output logic sink_o
);
  logic sink_r;
  logic sink_nxt;
  logic pwm_on;

  // Duty 0 never matches, duty 255 leaves one step off per period
  assign pwm_on = phase_i < duty_i;

  always_comb begin
    sink_nxt = 1'b0;
    case (ilp_pkg::ilp_chmode_e'(mode_i))
      ilp_pkg::CM_ON: sink_nxt = 1'b1;
      ilp_pkg::CM_PWM: sink_nxt = pwm_on;
      ilp_pkg::CM_GRP: sink_nxt = pwm_on & grp_on_i;
      default: sink_nxt = 1'b0;
    endcase
    if (!out_en_i) begin
      sink_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sink_r <= 1'b0;
    end else begin
      sink_r <= sink_nxt;
    end
  end

  assign sink_o = sink_r;

endmodule : ilp_chan

// >>> tb/ilp_core_props.sv
// Port-level assertions for the LED PWM controller core
`timescale 1ns/1ps
module ilp_core_props #(
  parameter int ADDR_PINS = 4
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic sda_o,
  input wire logic output_enable_n_i,
  input wire logic [ilp_pkg::NUM_CH-1:0] channel_sink_output_o,
  input wire logic [7:0] iref_code_o
);
  logic acc_w;
  logic bad_w;
  assign acc_w = psel_i && penable_i;
  assign bad_w = paddr_i[1:0] != 2'h0 || paddr_i[7:2] > 6'h1D;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence iref_wr_s;
    acc_w && pwrite_i && pready_o && paddr_i == 8'h10;
  endsequence
  sequence oe_high_s;
    output_enable_n_i [*4];
  endsequence
  // Two synchroniser stages plus the output register give the fourth sample
  chk_oe_gate: assert property (oe_high_s |-> channel_sink_output_o == '0)
    else $error("channel on while output enable high");
  chk_power_quiet: assert property ($rose(reset_n_i) |-> (channel_sink_output_o == '0) [*2])
    else $error("channel on right after reset");
  chk_iref_apply: assert property (iref_wr_s |=> iref_code_o == $past(pwdata_i[7:0]))
    else $error("current code not taken from write");
  chk_pready_high: assert property (pready_o)
    else $error("pready low");
  chk_err_flag: assert property (acc_w && bad_w |-> pslverr_o)
    else $error("no error on unmapped access");
  chk_err_quiet: assert property (!acc_w || !bad_w |-> !pslverr_o)
    else $error("error outside unmapped access");
  chk_err_zero: assert property (acc_w && bad_w && !pwrite_i |-> prdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_upper_zero: assert property (prdata_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_sda_level: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
endmodule : ilp_core_props

bind ilp_core ilp_core_props #(.ADDR_PINS(ADDR_PINS)) u_props (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .sda_o(sda_o), .output_enable_n_i(output_enable_n_i), .channel_sink_output_o(channel_sink_output_o),
  .iref_code_o(iref_code_o)
);

// >>> tb/ilp_i2c_master.sv
// Behavioural serial-bus master; a released line reads high through the pull-up
`timescale 1ns/1ps
module ilp_i2c_master (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Two clocks per step; the clock stands high between frames.
  // Bits are six clocks low and two high: the slave answers five clocks after a clock edge
  task automatic q();
    repeat (2) @(posedge clk_i);
  endtask : q
  task automatic start();
    sda_o <= 1'b1; q(); scl_o <= 1'b1; q(); sda_o <= 1'b0; q(); scl_o <= 1'b0; q();
  endtask : start
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_o <= b[i]; q(); q(); scl_o <= 1'b1; q(); scl_o <= 1'b0; q();
    end
    sda_o <= 1'b1; q(); q(); scl_o <= 1'b1; q(); ack = sda_i; scl_o <= 1'b0; q();
  endtask : send
  task automatic stop();
    sda_o <= 1'b0; q(); scl_o <= 1'b1; q(); sda_o <= 1'b1; q();
  endtask : stop
endmodule : ilp_i2c_master

// >>> tb/test_i2c_led_pwm_controller.sv
// Self-checking bench for the LED PWM controller core
`timescale 1ns/1ps
module test_i2c_led_pwm_controller;
  logic clk_i = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic oe_n = 1'b0;
  logic [2:0] flt = 3'h0;
  logic [3:0] pins = 4'h5;
  wire [31:0] prd;
  wire prdy, perr, sda_drv, sda_oe, scl, m_sda;
  wire [15:0] chan;
  wire [7:0] iref;
  logic glitch = 1'b0;
  wire sda_line = m_sda & (~sda_oe | sda_drv);
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int c;
  logic ack;
  logic [7:0] d;
  logic [7:0] duty_t[3];
  logic [32:0] exp_q[$];
  integer seed = 32'h61B9BA75;

  always #50 clk_i = ~clk_i;

  ilp_core u_dut (
    .clk_i(clk_i), .reset_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr),
    .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .scl_i(scl | glitch), .sda_i(sda_line),
    .sda_o(sda_drv), .sda_oe_o(sda_oe), .hardware_address_inputs_i(pins), .output_enable_n_i(oe_n),
    .open_load_i(flt[0]), .short_load_i(flt[1]), .overtemp_i(flt[2]), .channel_sink_output_o(chan),
    .iref_code_o(iref)
  );
  ilp_i2c_master u_m (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_o(m_sda));

  task automatic conclude();
    if (miscompares == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_read(input logic [32:0] got);
    logic [32:0] e;
    e = exp_q.pop_front();
    checks_done++;
    if (got !== e) begin
      miscompares++;
      $display("[FAIL] %0t read %h expected %h", $time, got, e);
    end
  endtask : cmp_read
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [32:0] e);
    @(posedge clk_i);
    if (!wr) exp_q.push_back(e);
    psel <= 1'b1; pwr <= wr; padr <= a; pwd <= wd;
    @(posedge clk_i);
    pen <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready
    do begin
      @(posedge clk_i);
    end while (prdy !== 1'b1);
    psel <= 1'b0; pen <= 1'b0;
  endtask : apb
  task automatic wr(input int idx, input logic [7:0] v);
    apb(1'b1, 8'(idx * 4), {24'h0, v}, 33'h0);
  endtask : wr
  task automatic rd(input int idx, input logic [32:0] e);
    apb(1'b0, 8'(idx * 4), 32'h0, e);
  endtask : rd
  // The window spans one whole period, so the count does not depend on phase
  task automatic count_on(input int ch, output int n);
    n = 0;
    repeat (256) begin
      @(posedge clk_i);
      if (chan[ch] === 1'b1) n++;
    end
  endtask : count_on

  // Read results are matched in order against the notes left by the driver
  always @(posedge clk_i) begin
    cycles++;
    if (psel && pen && prdy === 1'b1 && !pwr && exp_q.size() > 0) cmp_read({perr, prd});
    if (cycles > 20000) begin
      miscompares++;
      conclude();
    end
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_n <= 1'b1;
    rd(0, 33'h20);
    rd(1, 33'hFF);
    rd(6, 33'h76);
    for (int i = 14; i < 30; i++) rd(i, 33'h0);
    rd(30, {1'b1, 32'h0});
    apb(1'b0, 8'h05, 32'h0, {1'b1, 32'h0});
    d = 8'($random(seed));
    wr(4, d);
    rd(4, {25'h0, d});
    cmp_val({24'h0, iref}, {24'h0, d});
    flt <= 3'h5;
    repeat (6) @(posedge clk_i);
    flt <= 3'h0;
    rd(9, 33'h5);
    wr(9, 8'h05);
    rd(9, 33'h0);
    // Channels 0..3: off, on, own PWM, own PWM gated by a group duty of zero
    wr(1, 8'h00);
    wr(10, 8'hE4);
    wr(14, 8'h80);
    wr(15, 8'h80);
    wr(17, 8'hFF);
    duty_t = '{8'h00, 8'hFF, 8'($random(seed))};
    for (int i = 0; i < 3; i++) begin
      wr(16, duty_t[i]);
      repeat (2) @(posedge clk_i);
      count_on(2, c);
      cmp_val(c, {24'h0, duty_t[i]});
    end
    count_on(0, c);
    cmp_val(c, 0);
    count_on(1, c);
    cmp_val(c, 256);
    count_on(3, c);
    cmp_val(c, 0);
    wr(1, 8'hFF);
    repeat (2) @(posedge clk_i);
    count_on(3, c);
    cmp_val(c, 255);
    // Channels 0 and 2 at half duty; channel 2 lags by twice the stagger code
    d = 8'($random(seed)) & 8'h3F;
    wr(3, d);
    wr(10, 8'hE6);
    wr(16, 8'h80);
    repeat (2) @(posedge clk_i);
    c = 0;
    repeat (256) begin
      @(posedge clk_i);
      if (chan[0] === 1'b1 && chan[2] === 1'b0) c++;
    end
    cmp_val(c, 2 * d);
    oe_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    count_on(1, c);
    cmp_val(c, 0);
    oe_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    u_m.start();
    u_m.send(8'hCA, ack);
    cmp_val({31'h0, ack}, 0);
    u_m.send(8'd14, ack);
    u_m.send(8'h3C, ack);
    rd(14, 33'h80);
    u_m.stop();
    repeat (8) @(posedge clk_i);
    rd(14, 33'h3C);
    u_m.start();
    u_m.send(8'hC8, ack);
    cmp_val({31'h0, ack}, 1);
    u_m.stop();
    u_m.start();
    u_m.send(8'hEC, ack);
    cmp_val({31'h0, ack}, 0);
    u_m.send(8'd4, ack);
    // A one-clock spike on the low clock line must not add a bit
    fork
      u_m.send(8'h11, ack);
      begin
        @(posedge clk_i);
        glitch <= 1'b1;
        @(posedge clk_i);
        glitch <= 1'b0;
      end
    join
    u_m.stop();
    repeat (8) @(posedge clk_i);
    cmp_val({24'h0, iref}, 32'h11);
    u_m.start();
    u_m.send(8'h06, ack);
    u_m.send(8'hA5, ack);
    cmp_val({31'h0, ack}, 0);
    u_m.stop();
    repeat (8) @(posedge clk_i);
    rd(14, 33'h0);
    rd(0, 33'h20);
    rd(4, 33'h0);
    cmp_val({16'h0, chan}, 0);
    repeat (4) @(posedge clk_i);
    conclude();
  end
endmodule : test_i2c_led_pwm_controller
